/* File: include/area_decode_defs.svh */
`ifndef AREA_DECODE_DEFS_SVH
`define AREA_DECODE_DEFS_SVH
// ============================================================
// Address decode fields
`define AREA_FIELD_HI 28
`define AREA_FIELD_LO 26
`define AREA0_CODE 3'h0
`define AREA1_CODE 3'h1
`define AREA2_CODE 3'h2
`define AREA3_CODE 3'h3
`define AREA4_CODE 3'h4
// ============================================================
// Width codes shared by size fields, boot pins and requests
`define WIDTH_BYTE 2'h1
`define WIDTH_WORD 2'h2
// ============================================================
// Timing counts in clock cycles
`define SYNC_LAT 4'h2
`define BASE_CYC 4'h2
`define BURST_MIN_PITCH 4'h2
`define SDRAM_CAS_CYC 4'h2
// ============================================================
// Reset values
`define ADDR_RESET 32'h0000_0000
`define DATA_RESET 32'h0000_0000
`endif

/* File: include/area_decode_pkg.sv */
`default_nettype none
// ============================================================
// Shared types
package area_decode_pkg;
    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_ROW   = 3'b010,
        ST_BEAT  = 3'b011,
        ST_DONE  = 3'b100
    } seq_state_t;
endpackage : area_decode_pkg
`default_nettype wire

/* File: rtl/external_area_decode_align.sv */
`include "area_decode_defs.svh"
`default_nettype none
// Summary of operation
// - 16-bit little-endian lanes, longword low half first
// - 8-bit device: lowest lane, bytes ascending
// - Address bits 31 to 29 ignored
// - Code 000 selects area 0 strobes
// - Area 0 width from two pins
// - Area 0 waits zero to ten
// - Area 0 burst pitch two to ten
// - Code 001 internal, no external cycle
// - Code 010 selects area 2, size field
// - Area 2 strobes, zero to three waits
// - Wait pin ignored for area 2 SDRAM
// - Code 011 selects area 3, size field
// - Area 3 strobes, zero to three waits
// - Area 3 SDRAM row, column, masks, address
// - Code 100 selects area 4, size field
// - Area 4 waits to ten, wait pin extends
// - Reads full width, writes only written bytes
module external_area_decode_align
    import area_decode_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic [31:0] req_addr,
    input wire logic req_write,
    input wire logic [1:0] req_size,
    input wire logic [31:0] req_wdata,
    output logic req_busy,
    output logic req_done,
    output logic req_internal,
    output logic req_unmapped,
    output logic [31:0] req_rdata,
    input wire logic boot_width_pin_a,
    input wire logic boot_width_pin_b,
    input wire logic [2:0] area0_wait_field,
    input wire logic area0_burst_rom,
    input wire logic area2_size_hi,
    input wire logic area2_size_lo,
    input wire logic area2_wait_hi,
    input wire logic area2_wait_lo,
    input wire logic area2_is_sdram,
    input wire logic area3_size_hi,
    input wire logic area3_size_lo,
    input wire logic area3_wait_hi,
    input wire logic area3_wait_lo,
    input wire logic area3_is_sdram,
    input wire logic area4_size_hi,
    input wire logic area4_size_lo,
    input wire logic [2:0] area4_wait_field,
    input wire logic ext_wait_n,
    input wire logic [31:0] ext_rdata,
    output logic area0_select_n,
    output logic area2_select_n,
    output logic area3_select_n,
    output logic area4_select_n,
    output logic read_strobe_n,
    output logic byte_write_strobe_0,
    output logic byte_write_strobe_1,
    output logic byte_write_strobe_2,
    output logic byte_write_strobe_3,
    output logic byte_mask_lowest,
    output logic byte_mask_second,
    output logic byte_mask_third,
    output logic byte_mask_top,
    output logic row_strobe_upper,
    output logic row_strobe_lower,
    output logic column_strobe_upper,
    output logic column_strobe_lower,
    output logic sdram_write,
    output logic [25:0] ext_addr,
    output logic [31:0] ext_wdata,
    output logic ext_data_oe
);

    // ============================================================
    // Helper functions
    // Width code to bytes; reserved code reads as longword
    function automatic logic [2:0] width_bytes(input logic [1:0] code);
        case (code)
            `WIDTH_BYTE: width_bytes = 3'h1;
            `WIDTH_WORD: width_bytes = 3'h2;
            default: width_bytes = 3'h4;
        endcase
    endfunction : width_bytes

    // Three-bit wait field to wait cycles, 0 to 10
    function automatic logic [3:0] wait_cycles(input logic [2:0] f);
        case (f)
            3'h5: wait_cycles = 4'h6;
            3'h6: wait_cycles = 4'h8;
            3'h7: wait_cycles = 4'hA;
            default: wait_cycles = {1'b0, f};
        endcase
    endfunction : wait_cycles

    // ============================================================
    // Reset release and pin synchronisers
    logic rst_q1; // First reset stage
    logic rst_sync_n; // Released reset used everywhere
    logic [2:0] pin_q1; // Pin first stages, read only by pin_q2
    logic [2:0] pin_q2; // Pin stable copies
    logic [31:0] rd_q1; // Read bus first stage
    logic [31:0] rd_q2; // Read bus stable copy

    // Reset is released through two stages
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_q1 <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_sync_n <= rst_q1;
        end
    end

    // Pins and read bus pass two flops before use
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_q1 <= 3'h7;
            pin_q2 <= 3'h7;
            rd_q1 <= `DATA_RESET;
            rd_q2 <= `DATA_RESET;
        end else begin
            pin_q1 <= {ext_wait_n, boot_width_pin_b, boot_width_pin_a};
            pin_q2 <= pin_q1;
            rd_q1 <= ext_rdata;
            rd_q2 <= rd_q1;
        end
    end

    // ============================================================
    // Latched request and decode
    seq_state_t state; // Sequencer state
    logic [31:0] addr_q; // Request address
    logic [31:0] wdata_q; // Request write data
    logic [31:0] rbuf; // Merged read result
    logic write_q; // Request is a write
    logic [1:0] size_q; // Request width code
    logic [1:0] beat; // Current beat index
    logic [3:0] count; // Cycles left in beat
    logic [2:0] code; // Area code
    logic in_a0, in_a2, in_a3, in_a4; // Area hits
    logic sdram; // Access goes to SDRAM
    logic [3:0] waits; // Software waits of the area
    logic wait_en; // Wait pin honoured

    // Top three address bits never reach the decode
    assign code = addr_q[`AREA_FIELD_HI:`AREA_FIELD_LO];
    assign in_a0 = (code == `AREA0_CODE);
    assign in_a2 = (code == `AREA2_CODE);
    assign in_a3 = (code == `AREA3_CODE);
    assign in_a4 = (code == `AREA4_CODE);
    assign sdram = (in_a2 && area2_is_sdram) || (in_a3 && area3_is_sdram);
    // Wait pin only for ordinary memory in areas 2 and 4
    assign wait_en = (in_a2 && !area2_is_sdram) || in_a4;

    // Software waits by area
    always_comb begin
        case (code)
            `AREA0_CODE: waits = wait_cycles(area0_wait_field);
            `AREA2_CODE:
                waits = {2'h0, area2_wait_hi, area2_wait_lo};
            `AREA3_CODE:
                waits = {2'h0, area3_wait_hi, area3_wait_lo};
            `AREA4_CODE: waits = wait_cycles(area4_wait_field);
            default: waits = 4'h0;
        endcase
    end

    // ============================================================
    // Lane alignment of the current beat
    logic [2:0] devb; // Device width in bytes
    logic [2:0] reqb; // Request width in bytes
    logic [2:0] step; // Bytes moved per beat
    logic [1:0] last_beat; // Index of final beat
    logic [4:0] beat_off; // First request byte of beat
    logic [1:0] start; // Address low bits of beat
    logic [3:0] lanes; // Lanes carrying request bytes
    logic [31:0] wbus; // Write data placed on lanes
    logic [31:0] mbuf; // Result with this beat merged
    logic [3:0] beat_len; // Length of next beat

    // Device width from pins, size fields or SDRAM
    always_comb begin
        case (code)
            `AREA0_CODE: devb = width_bytes(pin_q2[1:0]);
            `AREA2_CODE: devb = area2_is_sdram ? 3'h4 :
                width_bytes({area2_size_hi, area2_size_lo});
            `AREA3_CODE: devb = area3_is_sdram ? 3'h4 :
                width_bytes({area3_size_hi, area3_size_lo});
            default:
                devb = width_bytes({area4_size_hi, area4_size_lo});
        endcase
    end

    // Wide access on narrow device splits into beats
    always_comb begin
        reqb = width_bytes(size_q);
        step = (reqb < devb) ? reqb : devb;
        if (reqb > step) begin
            last_beat = (reqb == 3'h4 && step == 3'h1) ? 2'h3 :
                2'h1;
        end else begin
            last_beat = 2'h0;
        end
        beat_off = 5'(beat) * 5'(step);
        start = addr_q[1:0] + beat_off[1:0];
    end

    // Request byte r goes to lane (address mod width)
    always_comb begin
        logic [1:0] b;
        logic [1:0] ln;
        logic [1:0] r;
        b = 2'h0;
        ln = 2'h0;
        r = 2'h0;
        lanes = 4'h0;
        wbus = `DATA_RESET;
        mbuf = rbuf;
        for (int i = 0; i < 4; i++) begin
            if (3'(i) < step) begin
                b = start + 2'(i);
                ln = b & 2'(devb - 3'h1);
                r = beat_off[1:0] + 2'(i);
                lanes[ln] = 1'b1;
                wbus[ln * 8 +: 8] = wdata_q[r * 8 +: 8];
                mbuf[r * 8 +: 8] = rd_q2[ln * 8 +: 8];
            end
        end
    end

    // Beat length: strobe, waits or burst pitch, sync tail
    always_comb begin
        if (sdram) begin
            beat_len = `SDRAM_CAS_CYC + `SYNC_LAT;
        end else if (in_a0 && area0_burst_rom && !write_q && beat != 2'h0)
        begin
            // Later burst beats run at the pitch
            beat_len = ((waits < `BURST_MIN_PITCH) ? `BURST_MIN_PITCH :
                waits) + `SYNC_LAT;
        end else begin
            beat_len = `BASE_CYC + waits + `SYNC_LAT;
        end
    end

    // ============================================================
    // Sequencer
    logic hold; // External wait stretches the beat
    // Sampled at the last strobe cycle before the tail
    assign hold = wait_en && !pin_q2[2] && count == `SYNC_LAT;

    // Request capture, beats and read merge
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= ST_IDLE;
            addr_q <= `ADDR_RESET;
            wdata_q <= `DATA_RESET;
            rbuf <= `DATA_RESET;
            write_q <= 1'b0;
            size_q <= 2'h0;
            beat <= 2'h0;
            count <= 4'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (req_valid) begin
                        addr_q <= req_addr;
                        wdata_q <= req_wdata;
                        write_q <= req_write;
                        size_q <= req_size;
                        rbuf <= `DATA_RESET;
                        // Each request starts at its first beat
                        beat <= 2'h0;
                        state <= ST_START;
                    end
                end
                ST_START: begin
                    count <= beat_len - 4'h1;
                    // Area 1 and unsupported areas skip the bus
                    if (!(in_a0 || in_a2 || in_a3 || in_a4)) begin
                        state <= ST_DONE;
                    end else if (sdram) begin
                        state <= ST_ROW;
                    end else begin
                        state <= ST_BEAT;
                    end
                end
                ST_ROW: begin
                    state <= ST_BEAT;
                end
                ST_BEAT: begin
                    if (count == 4'h0) begin
                        if (!write_q) begin
                            rbuf <= mbuf;
                        end
                        if (beat == last_beat) begin
                            state <= ST_DONE;
                        end else begin
                            beat <= beat + 2'h1;
                            // Next beat length uses next index
                            state <= ST_START;
                        end
                    end else if (!hold) begin
                        count <= count - 4'h1;
                    end
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // Requester side outputs
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            req_busy <= 1'b0;
            req_done <= 1'b0;
            req_internal <= 1'b0;
            req_unmapped <= 1'b0;
            req_rdata <= `DATA_RESET;
        end else begin
            req_busy <= (state == ST_IDLE) ? req_valid : state != ST_DONE;
            req_done <= (state == ST_DONE);
            req_internal <= (state == ST_START) && code == `AREA1_CODE;
            req_unmapped <= (state == ST_START) && code > `AREA4_CODE;
            if (state == ST_DONE) begin
                req_rdata <= rbuf;
            end
        end
    end

    // ============================================================
    // Memory side outputs, one cycle behind the sequencer
    logic active; // Ordinary or SDRAM beat in progress
    assign active = (state == ST_BEAT);

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            area0_select_n <= 1'b1;
            area2_select_n <= 1'b1;
            area3_select_n <= 1'b1;
            area4_select_n <= 1'b1;
            read_strobe_n <= 1'b1;
            {byte_write_strobe_3, byte_write_strobe_2,
                byte_write_strobe_1, byte_write_strobe_0} <= 4'h0;
            {byte_mask_top, byte_mask_third,
                byte_mask_second, byte_mask_lowest} <= 4'h0;
            {row_strobe_upper, row_strobe_lower} <= 2'h0;
            {column_strobe_upper, column_strobe_lower} <= 2'h0;
            sdram_write <= 1'b0;
            ext_addr <= 26'h000_0000;
            ext_wdata <= `DATA_RESET;
            ext_data_oe <= 1'b0;
        end else begin
            // Area 3 select spans row and column phases too; area 0 select also covers the start cycle
            area0_select_n <= !((active || state == ST_START) && in_a0
                && beat_len != 4'h0);
            area2_select_n <= !(active && in_a2);
            area3_select_n <= !((active || state == ST_ROW)
                && in_a3);
            area4_select_n <= !(active && in_a4);
            // Reads fetch the full width, no size given
            read_strobe_n <= !(active && !write_q && !sdram);
            {byte_write_strobe_3, byte_write_strobe_2,
                byte_write_strobe_1, byte_write_strobe_0} <=
                (active && write_q && !sdram) ? lanes : 4'h0;
            // SDRAM masks hide unwritten bytes only on writes
            {byte_mask_top, byte_mask_third,
                byte_mask_second, byte_mask_lowest} <=
                (active && sdram && write_q) ? ~lanes : 4'h0;
            {row_strobe_upper, row_strobe_lower} <=
                {2{state == ST_ROW}};
            {column_strobe_upper, column_strobe_lower} <=
                {2{active && sdram}};
            sdram_write <= sdram && write_q && (active || state == ST_ROW);
            // Row then column halves of the address on SDRAM
            if (state == ST_ROW) begin
                ext_addr <= {12'h000, addr_q[25:12]};
            end else if (sdram) begin
                ext_addr <= {14'h0000, addr_q[11:0]};
            end else begin
                ext_addr <= {addr_q[25:2], start};
            end
            ext_wdata <= wbus;
            ext_data_oe <= active && write_q;
        end
    end

    // ============================================================
    // Checks
    sequence row_phase;
        row_strobe_upper && row_strobe_lower;
    endsequence
    sequence col_phase;
        column_strobe_upper && column_strobe_lower && !row_strobe_upper;
    endsequence

    AST_SDRAM_ROW_COL: assert property (@(posedge clk)
        disable iff (!rst_sync_n) row_phase |=> col_phase)
        else $error("column phase did not follow row phase");

    AST_AREA1_QUIET: assert property (@(posedge clk)
        disable iff (!rst_sync_n) (state == ST_START && code == `AREA1_CODE)
        |=> (area0_select_n && area2_select_n && area3_select_n
        && area4_select_n && read_strobe_n)[*3])
        else $error("external select during internal area");

    AST_AREA3_SHADOW: assert property (@(posedge clk)
        disable iff (!rst_sync_n) (state == ST_BEAT && code == `AREA3_CODE)
        |=> !area3_select_n && area2_select_n)
        else $error("area 3 hit missed under shadow address");

    AST_READ_NO_WRITE: assert property (@(posedge clk)
        disable iff (!rst_sync_n) !read_strobe_n |->
        {byte_write_strobe_3, byte_write_strobe_2,
        byte_write_strobe_1, byte_write_strobe_0} == 4'h0)
        else $error("write strobe during read");

    AST_BYTE_LANE8: assert property (@(posedge clk)
        disable iff (!rst_sync_n) (active && devb == 3'h1 && write_q)
        |=> byte_write_strobe_0 && !byte_write_strobe_1
        && !byte_write_strobe_2 && !byte_write_strobe_3)
        else $error("8-bit device used upper lanes");

    AST_A0_WAIT_LEN: assert property (@(posedge clk)
        disable iff (!rst_sync_n)
        (state == ST_START && in_a0 && beat == 2'h0 && !sdram)
        |=> count == `BASE_CYC + wait_cycles(area0_wait_field)
        + `SYNC_LAT - 4'h1)
        else $error("area 0 beat length wrong");

    AST_SDRAM_NO_WAIT: assert property (@(posedge clk)
        disable iff (!rst_sync_n) (active && sdram && count != 4'h0)
        |=> count == $past(count) - 4'h1)
        else $error("SDRAM beat stretched by wait pin");

    AST_LONG16_BEATS: assert property (@(posedge clk)
        disable iff (!rst_sync_n) (active && devb == 3'h2
        && reqb == 3'h4 && beat == 2'h1) |-> start == 2'h2)
        else $error("second 16-bit beat not at offset 2");

    AST_BUSY_DONE: assert property (@(posedge clk)
        disable iff (!rst_sync_n) (state == ST_DONE) |=>
        req_done && !req_busy && req_rdata == $past(rbuf))
        else $error("result not handed over at completion");

endmodule : external_area_decode_align
`default_nettype wire

/* File: bench/ext_memory_model.sv */
`default_nettype none
// ============================================================
// Far-side static memory with a stall knob for the wait pin
module ext_memory_model (
    input wire logic clk,
    input wire logic [3:0] sel_n,
    input wire logic read_strobe_n,
    input wire logic [3:0] we,
    input wire logic [25:0] ext_addr,
    input wire logic [31:0] ext_wdata,
    input wire logic [2:0] dev_bytes,
    input wire logic [3:0] stall,
    output logic ext_wait_n,
    output logic [31:0] ext_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [int]; // Byte store by device address
    logic [3:0] held = 4'h0; // Cycles since a select fell
    logic [31:0] idle = 32'h0; // Changes every cycle when undriven
    int base; // Device-aligned address
    assign base = int'(ext_addr) & ~(int'(dev_bytes) - 1);
    // Wait pin low for the first stall cycles of each selection
    assign ext_wait_n = (&sel_n) || (held >= stall);
    // ============================================================
    // Write capture: only strobed lanes inside the device width
    always @(posedge clk) begin
        idle <= ~idle;
        held <= (&sel_n) ? 4'h0 : held + 4'h1;
        for (int k = 0; k < 4; k++) begin
            if (!(&sel_n) && we[k] && k < int'(dev_bytes)) begin
                mem[base + k] = ext_wdata[8*k +: 8];
            end
        end
    end
    // Read drive; the bus is not left showing stale data
    always_comb begin
        ext_rdata = idle;
        if (!read_strobe_n && !(&sel_n)) begin
            for (int k = 0; k < int'(dev_bytes); k++) begin
                ext_rdata[8*k +: 8] = mem.exists(base + k) ?
                    mem[base + k] : 8'h5A;
            end
        end
    end
endmodule : ext_memory_model
`default_nettype wire

/* File: bench/external_area_decode_align_bench.sv */
`default_nettype none
// ============================================================
// Self-checking bench with a byte-level reference memory
module external_area_decode_align_bench;
    import area_decode_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic [31:0] req_addr = 32'h0, req_wdata = 32'h0, rd, rnd = 32'hB627;
    logic [31:0] req_rdata, ext_rdata, wdat;
    logic [1:0] req_size = 2'h3, sz = 2'h3, row, flg, sd;
    logic [2:0] w = 3'h0, dev;
    logic [3:0] stall = 4'h0, sel_n, we, msk, sel_seen, we_seen;
    logic s2 = 1'b0, s3 = 1'b0, busy, done, intl, unm, rsn, wait_n;
    logic brom = 1'b0; // Area 0 burst ROM mode
    logic [25:0] xaddr;
    logic [7:0] refm [int]; // Reference bytes
    int err_count = 0, total_checks = 0, lat, l0, l1, code;
    assign dev = (sz == 2'h1) ? 3'h1 : (sz == 2'h2) ? 3'h2 : 3'h4;
    always #50 clk = ~clk; // 10 MHz
    external_area_decode_align u_external_area_decode_align (
        .clk(clk), .rst_n(rst_n), .req_valid(req_valid),
        .req_addr(req_addr), .req_write(req_write), .req_size(req_size),
        .req_wdata(req_wdata), .req_busy(busy), .req_done(done),
        .req_internal(intl), .req_unmapped(unm), .req_rdata(req_rdata),
        .boot_width_pin_a(sz[0]), .boot_width_pin_b(sz[1]),
        .area0_wait_field(w), .area0_burst_rom(brom),
        .area2_size_hi(sz[1]), .area2_size_lo(sz[0]),
        .area2_wait_hi(w[1]), .area2_wait_lo(w[0]), .area2_is_sdram(s2),
        .area3_size_hi(sz[1]), .area3_size_lo(sz[0]),
        .area3_wait_hi(w[1]), .area3_wait_lo(w[0]), .area3_is_sdram(s3),
        .area4_size_hi(sz[1]), .area4_size_lo(sz[0]),
        .area4_wait_field(w), .ext_wait_n(wait_n), .ext_rdata(ext_rdata),
        .area0_select_n(sel_n[0]), .area2_select_n(sel_n[1]),
        .area3_select_n(sel_n[2]), .area4_select_n(sel_n[3]),
        .read_strobe_n(rsn), .byte_write_strobe_0(we[0]),
        .byte_write_strobe_1(we[1]), .byte_write_strobe_2(we[2]),
        .byte_write_strobe_3(we[3]), .byte_mask_lowest(msk[0]),
        .byte_mask_second(msk[1]), .byte_mask_third(msk[2]),
        .byte_mask_top(msk[3]), .row_strobe_upper(row[1]),
        .row_strobe_lower(row[0]), .column_strobe_upper(),
        .column_strobe_lower(), .sdram_write(), .ext_addr(xaddr),
        .ext_wdata(wdat), .ext_data_oe()
    );
    ext_memory_model u_ext_memory_model (
        .clk(clk), .sel_n(sel_n), .read_strobe_n(rsn), .we(we),
        .ext_addr(xaddr), .ext_wdata(wdat), .dev_bytes(dev),
        .stall(stall), .ext_wait_n(wait_n), .ext_rdata(ext_rdata)
    );
    // Sticky record of what each transfer showed on the pins
    always @(posedge clk) begin
        sel_seen <= sel_seen | ~sel_n;
        we_seen <= we_seen | we;
        flg <= flg | {intl, unm};
        sd <= sd | {&row, |msk};
    end
    function automatic logic [31:0] lfsr(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    // Expected written lanes by device width, size and offset
    function automatic logic [3:0] lanes(logic [1:0] a, logic [1:0] s,
                                         logic [2:0] d);
        if (d == 3'h1) return 4'h1;
        if (d == 3'h2) return (s == 2'h1) ? {2'h0, a[0], ~a[0]} : 4'h3;
        if (s == 2'h1) return 4'h1 << a;
        return (s == 2'h2) ? (a[1] ? 4'hC : 4'h3) : 4'hF;
    endfunction : lanes
    // Wait table: 0..4 linear, then 6, 8, 10
    function automatic int wt(int v);
        return (v < 5) ? v : 2 * v - 4;
    endfunction : wt
    task automatic check(string what, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (e !== g) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : check
    // One request, held for one edge, then wait for completion
    task automatic xact(logic [31:0] a, logic wr, logic [1:0] s,
                        logic [31:0] d);
        @(negedge clk);
        req_addr = a;
        req_write = wr;
        req_size = s;
        req_wdata = d;
        req_valid = 1'b1;
        sel_seen = 4'h0;
        we_seen = 4'h0;
        flg = 2'h0;
        sd = 2'h0;
        @(negedge clk);
        req_valid = 1'b0;
        check("busy", 32'h1, busy);
        lat = 1;
        while (done !== 1'b1 && lat < 400) begin
            @(negedge clk);
            lat++;
        end
        if (lat >= 400) check("done", 32'h1, 32'h0);
        rd = req_rdata;
        check("idle", 32'h0, busy);
    endtask : xact
    // Write, read back, compare lanes and merged word
    task automatic acc(logic [31:0] a, logic [1:0] s);
        int nb;
        logic [31:0] e;
        nb = (s == 2'h1) ? 1 : (s == 2'h2) ? 2 : 4;
        e = 32'h0;
        for (int k = 0; k < nb; k++) refm[int'(a[25:0]) + k] = rnd[8*k +: 8];
        xact(a, 1'b1, s, rnd);
        check("wlanes", lanes(a[1:0], s, dev), we_seen);
        xact(a, 1'b0, s, 32'h0);
        for (int k = 0; k < nb; k++) e[8*k +: 8] = refm[int'(a[25:0]) + k];
        check("rdata", e, rd);
        check("rlanes", 32'h0, we_seen);
    endtask : acc
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    // Watchdog sized well above the expected run
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        complete_run();
    end
    // ============================================================
    // Main sequence
    initial begin
        logic [1:0] os [7];
        int oo [7];
        os = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
        oo = '{0, 1, 2, 3, 0, 2, 0};
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        for (int c = 0; c < 8; c++) begin
            rnd = lfsr(rnd);
            xact({rnd[31:29], c[2:0], 26'h0}, 1'b0, 2'h3, 32'h0);
            check("sel", {c == 4, c == 3, c == 2, c == 0}, sel_seen);
            check("flag", {c == 1, c > 4}, flg);
        end
        for (int ar = 0; ar < 3; ar++) begin
            code = (ar == 0) ? 0 : (ar == 1) ? 4 : 2;
            for (int z = 1; z < 4; z++) begin
                sz = z[1:0];
                for (int i = 0; i < 7; i++) begin
                    rnd = lfsr(rnd);
                    acc({rnd[31:29], code[2:0], 24'h0, oo[i][1:0]}, os[i]);
                end
            end
        end
        sz = 2'h1;
        for (int ar = 0; ar < 4; ar++) begin
            code = (ar == 0) ? 0 : ar + 1;
            for (int v = 0; v < 8; v++) begin
                w = v[2:0];
                xact({3'h0, code[2:0], 26'h0}, 1'b0, 2'h3, 32'h0);
                if (v == 0) l0 = lat;
                check("waits", (code == 0 || code == 4) ? 4 * wt(v) :
                      4 * (v % 4), lat - l0);
                if (code == 0) begin
                    // Later burst beats shrink to the burst pitch
                    l1 = lat - 3 * (wt(v) + 2 - ((v < 2) ? 2 : wt(v)));
                    brom = 1'b1;
                    xact(32'h0, 1'b0, 2'h3, 32'h0);
                    brom = 1'b0;
                    check("burst", l1, lat);
                end
            end
        end
        w = 3'h2;
        for (int ar = 0; ar < 3; ar++) begin
            s2 = (ar == 1);
            code = (ar == 2) ? 4 : 2;
            stall = 4'h0;
            xact({3'h0, code[2:0], 26'h0}, 1'b0, 2'h3, 32'h0);
            l0 = lat;
            stall = 4'h8;
            xact({3'h0, code[2:0], 26'h0}, 1'b0, 2'h3, 32'h0);
            check("waitpin", ar != 1, lat > l0);
        end
        stall = 4'h0;
        s2 = 1'b0;
        s3 = 1'b1;
        xact({3'h0, 3'h3, 26'h0123456}, 1'b1, 2'h3, rnd);
        check("sdram", 32'h6, {sel_seen[2], sd});
        xact({3'h0, 3'h3, 26'h0123455}, 1'b1, 2'h1, rnd);
        check("sdmask", 32'h7, {sel_seen[2], sd});
        complete_run();
    end
endmodule : external_area_decode_align_bench
`default_nettype wire
